// ===== src/dcs_defs.vh
// constants for the dma channel status register block
// ****************************************************************
// Overview of operation
// - each channel has a 16-bit writable buffer_b_base register, reset zero, giving the second buffer start.
// - each channel has a 16-bit writable peripheral pointer, reset zero, giving the peripheral address.
// - each channel has a 10-bit transfer tally in the low bits, upper bits read zero; a block is tally plus one transfers.
// - the clash status upper byte holds peripheral write clash flags, channel n at bit 8+n, cleared by software or by reset.
// - the clash status lower byte holds ram write clash flags, channel n at bit n, reset zero.
// - the read-only latest channel field at bits 11 to 8 of the state status resets to all ones.
// - after each transfer the latest channel field shows the channel number 0 to 7; codes 8 to 14 never appear.
// - state status bit n is the ping-pong select flag of channel n, one for buffer b, zero for buffer a, reset zero.
// - a read-only 16-bit latest ram pointer, reset zero, holds the last ram address used.
// - mode 00 continuous, 01 one-shot, 10 continuous ping-pong, 11 one-shot ping-pong with one block per buffer.
// - with the half option set the block event fires at half the data, otherwise after all of it.
// - each channel has a 16-bit primary buffer_a_base register giving the first buffer start.
// - direction one reads ram and writes the peripheral; zero reads the peripheral and writes ram.
// ****************************************************************
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH
// ****************************************************************
// register map: channel n at index {n, sub}, common block above
// ****************************************************************
`define DCS_SUB_CTRL 3'h0
`define DCS_SUB_ABASE 3'h1
`define DCS_SUB_BBASE 3'h2
`define DCS_SUB_PTR 3'h3
`define DCS_SUB_TALLY 3'h4
`define DCS_ADDR_CLASH 7'h40
`define DCS_ADDR_STATE 7'h41
`define DCS_ADDR_LRAM 7'h42
// ****************************************************************
// fields and reset values
// ****************************************************************
`define DCS_CTRL_MASK 16'hB003
`define DCS_CTRL_ON 15
`define DCS_CTRL_DIR 13
`define DCS_CTRL_HALF 12
`define DCS_MODE_ONESHOT 0
`define DCS_MODE_PP 1
`define DCS_TALLY_W 10
`define DCS_LCH_NONE 4'hF
`define DCS_RST16 16'h0000
`define DCS_FIFO_DEPTH 16
`define DCS_FIFO_AW 4
`endif

// ===== src/dcs_fifo.v
// synchronous fifo carrying transfer requests
`timescale 1ns/1ps
`default_nettype none
module dcs_fifo #(
    parameter W = 3,
    parameter D = 16,
    parameter AW = 4
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [W-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [W-1:0] out_data_out
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] fill_reg;
    wire push;
    wire pop;
    assign in_ready_out = (fill_reg != D[AW:0]) & ce_in;
    assign out_valid_out = (fill_reg != {(AW+1){1'b0}}) & ce_in;
    assign out_data_out = mem[rd_ptr_reg];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;
    always @(posedge sys_clk_in) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_in;
        end
    end
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            fill_reg <= {(AW+1){1'b0}};
        end else if (ce_in) begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                fill_reg <= fill_reg + 1'b1;
            end else if (pop & ~push) begin
                fill_reg <= fill_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== src/dcs_top.v
// eight-channel dma address, tally and shared status logic
`timescale 1ns/1ps
`default_nettype none
`include "dcs_defs.vh"
module dcs_top (
    input wire sys_clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire [6:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [15:0] reg_rdata_out,
    input wire req_valid_in,
    input wire [2:0] req_ch_in,
    output wire req_ready_out,
    input wire xfer_ready_in,
    output reg xfer_valid_out,
    output reg [2:0] xfer_ch_out,
    output reg xfer_dir_out,
    output reg [15:0] xfer_ram_addr_out,
    output reg [15:0] xfer_per_addr_out,
    output wire [7:0] blk_done_out,
    input wire cpu_per_wr_in,
    input wire [15:0] cpu_per_addr_in,
    input wire cpu_ram_wr_in,
    input wire [15:0] cpu_ram_addr_in
);
    // ****************************************************************
    // request queue
    // ****************************************************************
    wire fifo_valid;
    wire [2:0] fifo_ch;
    wire pop;
    wire fire;
    dcs_fifo #(
        .W(3),
        .D(`DCS_FIFO_DEPTH),
        .AW(`DCS_FIFO_AW)
    ) u_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .in_valid_in(req_valid_in),
        .in_ready_out(req_ready_out),
        .in_data_in(req_ch_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(xfer_ready_in),
        .out_data_out(fifo_ch)
    );

    // ****************************************************************
    // per-channel registers
    // ****************************************************************
    wire [7:0] on_w;
    wire [7:0] dir_w;
    wire [7:0] pp_w;
    wire [127:0] abase_w;
    wire [127:0] bbase_w;
    wire [127:0] ptr_w;
    wire [127:0] count_w;
    wire [127:0] rd_ch_w;
    // a queued request for a channel that is off is dropped, not held
    assign pop = fifo_valid & xfer_ready_in;
    assign fire = pop & on_w[fifo_ch];

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : ch_g
            localparam [2:0] CH = i;
            reg [15:0] ctrl_reg;
            reg [15:0] abase_reg;
            reg [15:0] bbase_reg;
            reg [15:0] ptr_reg;
            reg [`DCS_TALLY_W-1:0] tally_reg;
            reg [`DCS_TALLY_W-1:0] count_reg;
            reg pp_reg;
            reg done_reg;
            wire wr_sel;
            wire hit;
            wire last;
            wire half_pt;
            wire pp_mode;
            wire one_shot;
            assign wr_sel = reg_wr_in & ~reg_addr_in[6] & (reg_addr_in[5:3] == CH);
            assign hit = fire & (fifo_ch == CH);
            assign last = (count_reg == tally_reg);
            assign half_pt = (count_reg == {1'b0, tally_reg[`DCS_TALLY_W-1:1]});
            assign pp_mode = ctrl_reg[`DCS_MODE_PP];
            assign one_shot = ctrl_reg[`DCS_MODE_ONESHOT];
            always @(posedge sys_clk_in) begin
                if (rst_in) begin
                    ctrl_reg <= `DCS_RST16;
                    abase_reg <= `DCS_RST16;
                    bbase_reg <= `DCS_RST16;
                    ptr_reg <= `DCS_RST16;
                    tally_reg <= {`DCS_TALLY_W{1'b0}};
                    count_reg <= {`DCS_TALLY_W{1'b0}};
                    pp_reg <= 1'b0;
                    done_reg <= 1'b0;
                end else if (ce_in) begin
                    done_reg <= 1'b0;
                    if (wr_sel) begin
                        case (reg_addr_in[2:0])
                            `DCS_SUB_CTRL: begin
                                ctrl_reg <= reg_wdata_in & `DCS_CTRL_MASK;
                                // re-arming restarts the block in buffer a
                                count_reg <= {`DCS_TALLY_W{1'b0}};
                                pp_reg <= 1'b0;
                            end
                            `DCS_SUB_ABASE: abase_reg <= reg_wdata_in;
                            `DCS_SUB_BBASE: bbase_reg <= reg_wdata_in;
                            `DCS_SUB_PTR: ptr_reg <= reg_wdata_in;
                            `DCS_SUB_TALLY: tally_reg <= reg_wdata_in[`DCS_TALLY_W-1:0];
                            default: ;
                        endcase
                    end
                    if (hit) begin
                        if (ctrl_reg[`DCS_CTRL_HALF] ? half_pt : last) begin
                            done_reg <= 1'b1;
                        end
                        if (last) begin
                            count_reg <= {`DCS_TALLY_W{1'b0}};
                            if (pp_mode) begin
                                pp_reg <= ~pp_reg;
                            end
                            if (one_shot & (~pp_mode | pp_reg)) begin
                                ctrl_reg[`DCS_CTRL_ON] <= 1'b0;
                            end
                        end else begin
                            count_reg <= count_reg + 1'b1;
                        end
                    end
                end
            end
            assign on_w[i] = ctrl_reg[`DCS_CTRL_ON];
            assign dir_w[i] = ctrl_reg[`DCS_CTRL_DIR];
            assign pp_w[i] = pp_reg;
            assign blk_done_out[i] = done_reg;
            assign abase_w[i*16 +: 16] = abase_reg;
            assign bbase_w[i*16 +: 16] = bbase_reg;
            assign ptr_w[i*16 +: 16] = ptr_reg;
            assign count_w[i*16 +: 16] = {6'h00, count_reg};
            assign rd_ch_w[i*16 +: 16] =
                (reg_addr_in[2:0] == `DCS_SUB_CTRL) ? ctrl_reg :
                (reg_addr_in[2:0] == `DCS_SUB_ABASE) ? abase_reg :
                (reg_addr_in[2:0] == `DCS_SUB_BBASE) ? bbase_reg :
                (reg_addr_in[2:0] == `DCS_SUB_PTR) ? ptr_reg :
                (reg_addr_in[2:0] == `DCS_SUB_TALLY) ? {6'h00, tally_reg} : 16'h0000;
        end
    endgenerate

    // ****************************************************************
    // transfer issue and shared status
    // ****************************************************************
    reg [15:0] clash_reg;
    reg [3:0] lch_reg;
    reg [15:0] lram_reg;
    wire [15:0] sel_base;
    wire [15:0] ram_addr;
    wire [7:0] ch_onehot;
    wire per_clash;
    wire ram_clash;
    wire [15:0] clash_set;
    wire [15:0] clash_clr;
    wire [15:0] state_word;
    assign sel_base = pp_w[fifo_ch] ? bbase_w[{fifo_ch, 4'h0} +: 16]
                                    : abase_w[{fifo_ch, 4'h0} +: 16];
    // post-increment addressing from the selected buffer start
    assign ram_addr = sel_base + count_w[{fifo_ch, 4'h0} +: 16];
    assign ch_onehot = 8'h01 << xfer_ch_out;
    assign per_clash = xfer_valid_out & xfer_dir_out & cpu_per_wr_in &
                       (cpu_per_addr_in == xfer_per_addr_out);
    assign ram_clash = xfer_valid_out & ~xfer_dir_out & cpu_ram_wr_in &
                       (cpu_ram_addr_in == xfer_ram_addr_out);
    assign clash_set = {per_clash ? ch_onehot : 8'h00, ram_clash ? ch_onehot : 8'h00};
    // writing zero clears a flag; a same-cycle set wins
    assign clash_clr = (reg_wr_in & (reg_addr_in == `DCS_ADDR_CLASH)) ? ~reg_wdata_in
                                                                      : 16'h0000;
    assign state_word = {4'h0, lch_reg, pp_w};

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            clash_reg <= `DCS_RST16;
            lch_reg <= `DCS_LCH_NONE;
            lram_reg <= `DCS_RST16;
            xfer_valid_out <= 1'b0;
            xfer_ch_out <= 3'h0;
            xfer_dir_out <= 1'b0;
            xfer_ram_addr_out <= 16'h0000;
            xfer_per_addr_out <= 16'h0000;
            reg_rdata_out <= 16'h0000;
        end else if (ce_in) begin
            clash_reg <= (clash_reg & ~clash_clr) | clash_set;
            xfer_valid_out <= fire;
            if (fire) begin
                xfer_ch_out <= fifo_ch;
                xfer_dir_out <= dir_w[fifo_ch];
                xfer_ram_addr_out <= ram_addr;
                xfer_per_addr_out <= ptr_w[{fifo_ch, 4'h0} +: 16];
                lch_reg <= {1'b0, fifo_ch};
                lram_reg <= ram_addr;
            end
            if (reg_rd_in) begin
                if (~reg_addr_in[6]) begin
                    reg_rdata_out <= rd_ch_w[{reg_addr_in[5:3], 4'h0} +: 16];
                end else if (reg_addr_in == `DCS_ADDR_CLASH) begin
                    reg_rdata_out <= clash_reg;
                end else if (reg_addr_in == `DCS_ADDR_STATE) begin
                    reg_rdata_out <= state_word;
                end else if (reg_addr_in == `DCS_ADDR_LRAM) begin
                    reg_rdata_out <= lram_reg;
                end else begin
                    reg_rdata_out <= 16'h0000;
                end
            end else begin
                reg_rdata_out <= 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/dcs_checker.sv
// assertion checker for the dma channel status block
`timescale 1ns/1ps
`default_nettype none
module dcs_checker (
    input wire sys_clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire [6:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [15:0] reg_rdata_out,
    input wire xfer_valid_out,
    input wire [2:0] xfer_ch_out,
    input wire xfer_dir_out,
    input wire [15:0] xfer_ram_addr_out,
    input wire [15:0] xfer_per_addr_out,
    input wire [7:0] blk_done_out,
    input wire cpu_per_wr_in,
    input wire [15:0] cpu_per_addr_in,
    input wire cpu_ram_wr_in,
    input wire [15:0] cpu_ram_addr_in
);
    reg seen_reg;
    wire seen_now = seen_reg | xfer_valid_out;
    wire rd_ok = reg_rd_in & ce_in;
    wire st_rd = rd_ok & (reg_addr_in == 7'h41);
    // transfer seen since reset; the status read in the same cycle already shows it
    always @(posedge sys_clk_in) begin
        if (rst_in)
            seen_reg <= 1'b0;
        else if (xfer_valid_out)
            seen_reg <= 1'b1;
    end
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    // ****************************************************************
    // properties
    // ****************************************************************
    property p_tally_hi;
        rd_ok && !reg_addr_in[6] && reg_addr_in[2:0] == 3'h4 |=> reg_rdata_out[15:10] == 6'h00;
    endproperty
    a_tally_hi: assert property (p_tally_hi) else $error("tally upper bits set");
    property p_latest_ch;
        st_rd |=> reg_rdata_out[15:8] == ($past(seen_now) ? {5'h00, $past(xfer_ch_out)} : 8'h0F);
    endproperty
    a_latest_ch: assert property (p_latest_ch) else $error("latest channel wrong");
    property p_pp_reset;
        st_rd && !seen_now |=> reg_rdata_out[7:0] == 8'h00;
    endproperty
    a_pp_reset: assert property (p_pp_reset) else $error("select flags not zero");
    property p_latest_ram;
        rd_ok && reg_addr_in == 7'h42 |=> reg_rdata_out == $past(xfer_ram_addr_out);
    endproperty
    a_latest_ram: assert property (p_latest_ram) else $error("ram pointer wrong");
    property p_per_clash;
        ce_in && xfer_valid_out && xfer_dir_out && cpu_per_wr_in && cpu_per_addr_in == xfer_per_addr_out
            ##1 rd_ok && reg_addr_in == 7'h40 |=> reg_rdata_out[{1'b1, $past(xfer_ch_out, 2)}];
    endproperty
    a_per_clash: assert property (p_per_clash) else $error("periph clash lost");
    property p_ram_clash;
        ce_in && xfer_valid_out && !xfer_dir_out && cpu_ram_wr_in && cpu_ram_addr_in == xfer_ram_addr_out
            ##1 rd_ok && reg_addr_in == 7'h40 |=> reg_rdata_out[$past(xfer_ch_out, 2)];
    endproperty
    a_ram_clash: assert property (p_ram_clash) else $error("ram clash lost");
    property p_blk_done;
        blk_done_out != 8'h00 |-> xfer_valid_out && blk_done_out == 8'h01 << xfer_ch_out;
    endproperty
    a_blk_done: assert property (p_blk_done) else $error("block event stray");
    property p_readback;
        reg_wr_in && ce_in && !reg_addr_in[6] && reg_addr_in[2:0] inside {3'h1, 3'h2, 3'h3}
            ##1 rd_ok && $stable(reg_addr_in) |=> reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");
endmodule
bind dcs_top dcs_checker u_dcs_checker (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .xfer_valid_out(xfer_valid_out), .xfer_ch_out(xfer_ch_out),
    .xfer_dir_out(xfer_dir_out), .xfer_ram_addr_out(xfer_ram_addr_out),
    .xfer_per_addr_out(xfer_per_addr_out), .blk_done_out(blk_done_out),
    .cpu_per_wr_in(cpu_per_wr_in), .cpu_per_addr_in(cpu_per_addr_in),
    .cpu_ram_wr_in(cpu_ram_wr_in), .cpu_ram_addr_in(cpu_ram_addr_in)
);
`default_nettype wire

// ===== test/dcs_far_model.sv
// data side model: transfer acceptance and cpu writes beside the dma
`timescale 1ns/1ps
`default_nettype none
module dcs_far_model (
    input wire sys_clk_in,
    input wire hold_in,
    input wire slow_in,
    input wire clash_in,
    input wire xfer_valid_in,
    input wire xfer_dir_in,
    input wire [15:0] ram_addr_in,
    input wire [15:0] per_addr_in,
    output reg ready_out,
    output wire per_wr_out,
    output wire [15:0] per_addr_out,
    output wire ram_wr_out,
    output wire [15:0] ram_addr_out
);
    reg noise_reg;
    initial ready_out = 1'b1;
    initial noise_reg = 1'b0;
    always @(posedge sys_clk_in) begin
        ready_out <= !hold_in && (!slow_in || $urandom_range(1) == 1);
        noise_reg <= $urandom_range(1) == 1;
    end
    // background cpu writes use inverted targets so they never collide unless commanded
    assign per_wr_out = xfer_valid_in && (clash_in ? xfer_dir_in : noise_reg);
    assign per_addr_out = clash_in ? per_addr_in : ~per_addr_in;
    assign ram_wr_out = xfer_valid_in && (clash_in ? !xfer_dir_in : noise_reg);
    assign ram_addr_out = clash_in ? ram_addr_in : ~ram_addr_in;
endmodule
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the dma channel status block
`timescale 1ns/1ps
`default_nettype none
module tb;
    reg sys_clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg reg_wr_in = 1'b0;
    reg reg_rd_in = 1'b0;
    reg req_valid_in = 1'b0;
    reg hold = 1'b0;
    reg slow = 1'b0;
    reg clash = 1'b0;
    reg on = 1'b0;
    reg ce = 1'b1;
    reg [2:0] req_ch_in = 3'h0;
    reg [6:0] reg_addr_in = 7'h00;
    reg [15:0] reg_wdata_in = 16'h0000;
    reg [15:0] cl_v = 16'h0000;
    reg [15:0] lram = 16'h0000;
    reg [3:0] lch = 4'hF;
    reg [7:0] pp = 8'h00;
    reg [15:0] d, ctl;
    reg [15:0] val [1:4];
    reg [9:0] idx, hp;
    integer n_fail = 0, total_checks = 0, cyc = 0, nx, i, k, w;
    wire [15:0] reg_rdata_out, ram_a, per_a, c_pa, c_ra;
    wire [7:0] blk_done_out;
    wire [2:0] xch;
    wire rdy, xv, xdir, c_pw, c_rw, req_ready_out;
    dcs_top u_dcs_top (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .req_valid_in(req_valid_in), .req_ch_in(req_ch_in),
        .req_ready_out(req_ready_out), .xfer_ready_in(rdy), .xfer_valid_out(xv),
        .xfer_ch_out(xch), .xfer_dir_out(xdir), .xfer_ram_addr_out(ram_a),
        .xfer_per_addr_out(per_a), .blk_done_out(blk_done_out), .cpu_per_wr_in(c_pw),
        .cpu_per_addr_in(c_pa), .cpu_ram_wr_in(c_rw), .cpu_ram_addr_in(c_ra)
    );
    dcs_far_model u_dcs_far_model (
        .sys_clk_in(sys_clk_in), .hold_in(hold), .slow_in(slow), .clash_in(clash),
        .xfer_valid_in(xv), .xfer_dir_in(xdir), .ram_addr_in(ram_a), .per_addr_in(per_a),
        .ready_out(rdy), .per_wr_out(c_pw), .per_addr_out(c_pa), .ram_wr_out(c_rw),
        .ram_addr_out(c_ra)
    );
    // ****************************************************************
    // bus tasks and expectations
    // ****************************************************************
    always #20 sys_clk_in = ~sys_clk_in;
    task print_verdict;
        begin
            $display("checks %0d errors %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task check(input [15:0] g, input [15:0] e);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("ERROR t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    // strobes drop at the edge and rise 1 ns later, so back-to-back calls never collide
    task wr(input [6:0] a, input [15:0] v);
        begin
            reg_addr_in <= a;
            reg_wdata_in <= v;
            reg_wr_in <= 1'b1;
            @(posedge sys_clk_in);
            reg_wr_in <= 1'b0;
            #1;
        end
    endtask
    task rd(input [6:0] a);
        begin
            reg_addr_in <= a;
            reg_rd_in <= 1'b1;
            @(posedge sys_clk_in);
            reg_rd_in <= 1'b0;
            #1 d = reg_rdata_out;
        end
    endtask
    task rdc(input [6:0] a, input [15:0] e);
        begin
            rd(a);
            check(d, e);
        end
    endtask
    // one-shot modes stop after one block, or two when ping-pong is on; an off channel moves none
    function [15:0] n_exp(input [15:0] c, input [15:0] t, input [15:0] n);
        n_exp = !c[15] ? 16'h0000 : (!c[0] || n < (t + 1) * (c[1] + 1) ? n : (t + 1) * (c[1] + 1));
    endfunction
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            print_verdict;
        end
    end
    always @(posedge sys_clk_in) begin
        #1;
        if (xv === 1'b1) begin
            nx = nx + 1;
            lram = (pp[req_ch_in] ? val[2] : val[1]) + idx;
            lch = {1'b0, req_ch_in};
            check({12'h000, on, xch}, {12'h001, req_ch_in});
            check(ram_a, lram);
            check(per_a, val[3]);
            check({xdir, 7'h00, blk_done_out},
                  {ctl[13], 7'h00, (idx == hp) ? 8'h01 << req_ch_in : 8'h00});
            if (clash)
                cl_v = cl_v | (16'h0001 << {xdir, req_ch_in});
            if (idx == val[4][9:0]) begin
                on = on & !(ctl[0] & (!ctl[1] | pp[req_ch_in]));
                pp[req_ch_in] = pp[req_ch_in] ^ ctl[1];
                idx = 10'h000;
            end else
                idx = idx + 10'h001;
        end
    end
    task run(input [2:0] ch);
        begin
            wr({ch, 3'h0}, 16'h0000);
            for (k = 1; k < 5; k = k + 1) begin
                val[k] = k == 4 ? 16'hFC00 | $urandom_range(3) : $urandom;
                wr({ch, k[2:0]}, val[k]);
                rdc({ch, k[2:0]},
                    val[k] & (k == 4 ? 16'h03FF : 16'hFFFF));
            end
            hp = ctl[12] ? val[4][9:1] : val[4][9:0];
            idx = 10'h000;
            pp[ch] = 1'b0;
            on = ctl[15];
            nx = 0;
            wr({ch, 3'h0}, ctl);
            req_ch_in <= ch;
            req_valid_in <= 1'b1;
            k = 0;
            for (w = 0; w < 60 && k < (hold ? 40 : 3 * val[4][9:0] + 4); w = w + 1) begin
                @(negedge sys_clk_in);
                if (req_ready_out === 1'b1)
                    k = k + 1;
                @(posedge sys_clk_in);
            end
            req_valid_in <= 1'b0;
            if (hold)
                check(k[15:0], 16'd16);
            hold <= 1'b0;
            for (w = 0; w < 60 + 4 * k; w = w + 1)
                rd({5'h10, w[1:0]});
            check(nx[15:0], n_exp(ctl, {6'h00, val[4][9:0]}, k[15:0]));
            rdc(7'h41, {4'h0, lch, pp});
            rdc(7'h42, lram);
            rdc(7'h40, cl_v);
            wr(7'h40, 16'hFFFF);
            rdc(7'h40, cl_v);
            wr(7'h40, 16'h0000);
            cl_v = 16'h0000;
        end
    endtask
    initial begin
        w = $urandom(16040);
        repeat (8) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        for (i = 0; i < 128; i = i + 1)
            rdc(i[6:0], i == 65 ? 16'h0F00 : 16'h0000);
        wr(7'h42, 16'hFFFF);
        rdc(7'h42, 16'h0000);
        // a frozen block keeps its read data and ignores a write
        rd(7'h41);
        ce <= 1'b0;
        wr(7'h01, 16'hA5A5);
        check(reg_rdata_out, {4'h0, lch, pp});
        ce <= 1'b1;
        rdc(7'h01, 16'h0000);
        for (i = 0; i < 6; i = i + 1) begin
            ctl = {i != 5, 1'b0, i[0], i == 2, 10'h000, i[1:0]};
            clash <= i[1];
            slow <= i[0];
            hold <= i == 4;
            run($urandom_range(7));
        end
        print_verdict;
    end
endmodule
`default_nettype wire
